// ==== design/rb_defs.svh ====
// register bank constants: offsets, field masks, reset values
// assumes inclusion by bare name from package and design files
`ifndef RB_DEFS_SVH
`define RB_DEFS_SVH

// widths
`define RB_DW 8
`define RB_AW 3

// register offsets
`define RB_OFS_BASE 3'h0
`define RB_OFS_SET 3'h1
`define RB_OFS_CLEAR_ALIAS 3'h2
`define RB_OFS_TOGGLE_ALIAS 3'h3
`define RB_OFS_STAT 3'h4
`define RB_OFS_WO 3'h5
`define RB_OFS_DBG 3'h6

// implemented (non-reserved) bits of each register
`define RB_BASE_MASK 8'h3f
`define RB_STAT_MASK 8'h7f
`define RB_WO_MASK 8'hff
`define RB_DBG_MASK 8'h0f

// reset values
`define RB_BASE_RST 8'h00
`define RB_WO_RST 8'h00
`define RB_DBG_RST 8'h00

// value returned for write-only and unmapped reads
`define RB_RD_NONE 8'h00

`endif

// ==== design/rb_pkg.sv ====
// register bank types: access request carried as one packed struct
// assumes rb_defs.svh sits on the include path
`include "rb_defs.svh"

package rb_pkg;

	typedef logic [`RB_DW-1:0] rb_data_t;
	typedef logic [`RB_AW-1:0] rb_addr_t;

	typedef struct packed {
		logic wr;
		logic rd;
		rb_addr_t addr;
		rb_data_t wdata;
	} rb_acc_s;

endpackage : rb_pkg

// ==== design/rb_bank.sv ====
// register bank with base register, set/clear/toggle aliases, status, write-only and debug regs
// assumes one access per cycle on acc, synchronous to clk_sys, and software zeroing reserved bits
//
// Summary of operation
// RQ1 - read/write bits return last written value and accept new writes
// RQ2 - writes to read-only bits are silently discarded
// RQ3 - write-only bits read back no defined value; this bank returns zero
// RQ4 - reserved bits always read as zero whatever was written
// RQ5 - software writes zero to every reserved bit position
// RQ6 - reset loads reset values; soft reset spares the debug register
// RQ7 - base register and all its aliases read the same base content
// RQ8 - a one written to the clear alias clears that base bit
// RQ9 - a one written to the set alias sets that base bit
// RQ10 - a one written to the toggle alias inverts that base bit
// RQ11 - zero bits written through an alias leave base bits unchanged
`timescale 1ns/1ps
`include "rb_defs.svh"

module rb_bank
	import rb_pkg::*;
(
	// clock and resets
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic soft_rst,
	// register access
	input wire rb_acc_s acc,
	output rb_data_t rdata_reg,
	output logic rvalid_reg,
	// block-side state
	input wire rb_data_t status_in,
	output rb_data_t base_reg,
	output rb_data_t wo_reg,
	output rb_data_t dbg_reg
);

	rb_data_t base_next;
	rb_data_t rdata_next;
	logic wr_base;
	logic wr_set;
	logic wr_clear;
	logic wr_toggle;

	assign wr_base = acc.wr && (acc.addr == `RB_OFS_BASE);
	assign wr_set = acc.wr && (acc.addr == `RB_OFS_SET);
	assign wr_clear = acc.wr && (acc.addr == `RB_OFS_CLEAR_ALIAS);
	assign wr_toggle = acc.wr && (acc.addr == `RB_OFS_TOGGLE_ALIAS);

	// base register next value
	always_comb begin
		base_next = base_reg;
		// RQ1 direct write
		if (wr_base) begin
			base_next = acc.wdata;
		end
		// RQ9 set alias
		if (wr_set) begin
			base_next = base_reg | acc.wdata;
		end
		// RQ8 clear alias
		if (wr_clear) begin
			base_next = base_reg & ~acc.wdata;
		end
		// RQ10 toggle alias
		// RQ11 zeros leave bits
		if (wr_toggle) begin
			base_next = base_reg ^ acc.wdata;
		end
		// RQ4 reserved held zero
		base_next = base_next & `RB_BASE_MASK;
	end

	// RQ6 reset values
	always_ff @(posedge clk_sys) begin
		if (sys_rst || soft_rst) begin
			base_reg <= `RB_BASE_RST;
		end else begin
			base_reg <= base_next;
		end
	end

	// write-only register
	always_ff @(posedge clk_sys) begin
		if (sys_rst || soft_rst) begin
			wo_reg <= `RB_WO_RST;
		end else if (acc.wr && (acc.addr == `RB_OFS_WO)) begin
			wo_reg <= acc.wdata & `RB_WO_MASK;
		end
	end

	// RQ6 debug survives soft reset
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			dbg_reg <= `RB_DBG_RST;
		end else if (acc.wr && (acc.addr == `RB_OFS_DBG)) begin
			dbg_reg <= acc.wdata & `RB_DBG_MASK;
		end
	end

	// read mux; status writes fall through and are ignored
	always_comb begin
		rdata_next = `RB_RD_NONE;
		case (acc.addr)
			// RQ7 aliases read base
			`RB_OFS_BASE, `RB_OFS_SET, `RB_OFS_CLEAR_ALIAS, `RB_OFS_TOGGLE_ALIAS: begin
				rdata_next = base_reg;
			end
			// RQ2 read-only status
			`RB_OFS_STAT: begin
				rdata_next = status_in & `RB_STAT_MASK;
			end
			// RQ3 write-only reads zero
			`RB_OFS_WO: begin
				rdata_next = `RB_RD_NONE;
			end
			`RB_OFS_DBG: begin
				rdata_next = dbg_reg;
			end
			default: begin
				rdata_next = `RB_RD_NONE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rdata_reg <= `RB_RD_NONE;
			rvalid_reg <= 1'h0;
		end else begin
			rdata_reg <= acc.rd ? rdata_next : `RB_RD_NONE;
			rvalid_reg <= acc.rd;
		end
	end

	// checks
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	sequence base_write_s;
		wr_base && !soft_rst;
	endsequence

	sequence base_read_s;
		acc.rd && (acc.addr == `RB_OFS_BASE) && !acc.wr && !soft_rst;
	endsequence

	sequence alias_write_s;
		(wr_set || wr_clear || wr_toggle) && !soft_rst;
	endsequence

	rw_readback_a: assert property ( // RQ1
		base_write_s ##1 base_read_s |=> rvalid_reg
			&& rdata_reg == ($past(acc.wdata, 2) & `RB_BASE_MASK))
		else $error("base readback differs from last write");

	ro_ignore_a: assert property ( // RQ2
		acc.wr && acc.addr == `RB_OFS_STAT && !soft_rst
			|=> base_reg == $past(base_reg) && dbg_reg == $past(dbg_reg)
			&& wo_reg == $past(wo_reg))
		else $error("status write changed a register");

	wo_read_a: assert property ( // RQ3
		acc.rd && acc.addr == `RB_OFS_WO |=> rvalid_reg && rdata_reg == `RB_RD_NONE)
		else $error("write-only read not zero");

	rsvd_zero_a: assert property ( // RQ4
		(base_reg & ~`RB_BASE_MASK) == 8'h00 && (dbg_reg & ~`RB_DBG_MASK) == 8'h00)
		else $error("reserved bit set");

	reset_value_a: assert property ( // RQ6
		$past(sys_rst) |-> base_reg == `RB_BASE_RST && dbg_reg == `RB_DBG_RST
			&& wo_reg == `RB_WO_RST && !rvalid_reg)
		else $error("reset value wrong");

	soft_keep_a: assert property ( // RQ6
		soft_rst |=> base_reg == `RB_BASE_RST && wo_reg == `RB_WO_RST
			&& (dbg_reg == $past(dbg_reg) || $past(acc.wr)))
		else $error("soft reset handled wrong");

	alias_read_a: assert property ( // RQ7
		acc.rd && acc.addr <= `RB_OFS_TOGGLE_ALIAS |=> rdata_reg == $past(base_reg))
		else $error("alias read differs from base");

	clear_alias_a: assert property ( // RQ8
		wr_clear && !soft_rst |=> (base_reg & $past(acc.wdata)) == 8'h00)
		else $error("clear alias left bit set");

	set_alias_a: assert property ( // RQ9
		wr_set && !soft_rst
			|=> (base_reg & $past(acc.wdata)) == ($past(acc.wdata) & `RB_BASE_MASK))
		else $error("set alias left bit clear");

	toggle_alias_a: assert property ( // RQ10
		wr_toggle && !soft_rst
			|=> ((base_reg ^ $past(base_reg)) & $past(acc.wdata))
			== ($past(acc.wdata) & `RB_BASE_MASK))
		else $error("toggle alias did not invert");

	alias_keep_a: assert property ( // RQ11
		alias_write_s
			|=> ((base_reg ^ $past(base_reg)) & ~$past(acc.wdata)) == 8'h00)
		else $error("alias changed a zero-written bit");

	base_hold_a: assert property ( // RQ1
		!(wr_base || wr_set || wr_clear || wr_toggle || soft_rst)
			|=> $stable(base_reg))
		else $error("base changed without a write");

	dbg_write_a: assert property ( // RQ1
		acc.wr && acc.addr == `RB_OFS_DBG
			|=> dbg_reg == ($past(acc.wdata) & `RB_DBG_MASK))
		else $error("debug write did not land");

	read_pulse_a: assert property ( // RQ1
		!$past(sys_rst) |-> rvalid_reg == $past(acc.rd)
			&& (rvalid_reg || rdata_reg == `RB_RD_NONE))
		else $error("read strobe or idle data wrong");

	status_read_a: assert property ( // RQ4
		acc.rd && acc.addr == `RB_OFS_STAT
			|=> rdata_reg == ($past(status_in) & `RB_STAT_MASK))
		else $error("status read wrong");

	wo_write_a: assert property ( // RQ3
		acc.wr && acc.addr == `RB_OFS_WO && !soft_rst
			|=> wo_reg == ($past(acc.wdata) & `RB_WO_MASK))
		else $error("write-only register did not store");

	dbg_keep_a: assert property ( // RQ6
		soft_rst && !(acc.wr && acc.addr == `RB_OFS_DBG)
			|=> $stable(dbg_reg))
		else $error("soft reset touched debug register");

endmodule : rb_bank

// ==== dv/tb_register_access_conventions.sv ====
// bench for the register bank: reset, access kinds, aliases, soft reset
// assumes rb_pkg and rb_bank compiled first, rb_defs.svh on the include path
`timescale 1ns/1ps
`include "rb_defs.svh"

module tb_register_access_conventions import rb_pkg::*;;
	logic clk_sys = 1'h0;
	logic sys_rst = 1'h1;
	logic soft_rst = 1'h0;
	logic rvalid_reg;
	rb_acc_s acc = '0;
	rb_data_t status_in = 8'h00;
	rb_data_t rdata_reg, base_reg, wo_reg, dbg_reg, v;
	int bad_count = 0;
	int comparisons = 0;

	rb_bank DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .soft_rst(soft_rst), .acc(acc),
		.rdata_reg(rdata_reg), .rvalid_reg(rvalid_reg), .status_in(status_in),
		.base_reg(base_reg), .wo_reg(wo_reg), .dbg_reg(dbg_reg));

	initial begin
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic chk(input string what, input rb_data_t exp, input rb_data_t got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// requests are held until the next falling edge, after the taking edge
	task automatic wr(input rb_addr_t a, input rb_data_t d);
		acc = '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
		@(negedge clk_sys);
	endtask : wr

	task automatic rd(input rb_addr_t a, output rb_data_t d);
		acc = '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
		@(negedge clk_sys);
		chk("rvalid", 8'h01, {7'h00, rvalid_reg});
		d = rdata_reg;
	endtask : rd

	task automatic idle();
		acc = '0;
		@(negedge clk_sys);
	endtask : idle

	task automatic t_reset();
		chk("base after reset", 8'h00, base_reg);
		chk("wo after reset", 8'h00, wo_reg);
		chk("dbg after reset", 8'h00, dbg_reg);
	endtask : t_reset

	task automatic t_rw();
		wr(`RB_OFS_BASE, 8'h2a);
		rd(`RB_OFS_BASE, v);
		chk("base readback", 8'h2a, v);
		wr(`RB_OFS_BASE, 8'hff);
		rd(`RB_OFS_BASE, v);
		chk("base reserved", 8'h3f, v);
		idle();
		chk("rvalid idle", 8'h00, {7'h00, rvalid_reg});
		chk("rdata idle", 8'h00, rdata_reg);
	endtask : t_rw

	task automatic t_alias();
		wr(`RB_OFS_BASE, 8'h0f);
		wr(`RB_OFS_SET, 8'h30);
		chk("set alias", 8'h3f, base_reg);
		wr(`RB_OFS_CLEAR_ALIAS, 8'h05);
		chk("clear alias", 8'h3a, base_reg);
		wr(`RB_OFS_TOGGLE_ALIAS, 8'h21);
		chk("toggle alias", 8'h1b, base_reg);
		for (int i = 0; i < 4; i++) begin
			rd(i[2:0], v);
			chk("pair read", 8'h1b, v);
		end
		idle();
	endtask : t_alias

	task automatic t_ro();
		status_in = 8'ha5;
		wr(`RB_OFS_STAT, 8'h5a);
		chk("base after status write", 8'h1b, base_reg);
		rd(`RB_OFS_STAT, v);
		chk("status read", 8'h25, v);
		idle();
	endtask : t_ro

	task automatic t_soft();
		wr(`RB_OFS_WO, 8'h5c);
		chk("wo store", 8'h5c, wo_reg);
		wr(`RB_OFS_DBG, 8'hf3);
		chk("dbg reserved", 8'h03, dbg_reg);
		idle();
		soft_rst = 1'h1;
		@(negedge clk_sys);
		soft_rst = 1'h0;
		chk("base soft", 8'h00, base_reg);
		chk("wo soft", 8'h00, wo_reg);
		chk("dbg kept", 8'h03, dbg_reg);
	endtask : t_soft

	task automatic conclude();
		$display("checks %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : conclude

	initial begin
		#2000;
		bad_count++;
		conclude();
	end

	initial begin
		repeat (4) @(negedge clk_sys);
		sys_rst = 1'b0;
		@(negedge clk_sys);
		t_reset();
		t_rw();
		t_alias();
		t_ro();
		t_soft();
		conclude();
	end
endmodule : tb_register_access_conventions
